/* File: src/tw_pkg.sv */
// constants for the shift-unit two-wire master
// assumes a 10 MHz system clock
package tw_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned STD_BPS = 100000;
  localparam int unsigned FAST_BPS = 400000;
  // quarter bit period in cycles, rounded up so the rate stays below the limit
  localparam int unsigned STD_QTR = (CLK_HZ + 4 * STD_BPS - 1) / (4 * STD_BPS);
  localparam int unsigned FAST_QTR = (CLK_HZ + 4 * FAST_BPS - 1) / (4 * FAST_BPS);
  localparam logic [7:0] STD_QTR_C = 8'(STD_QTR);
  localparam logic [7:0] FAST_QTR_C = 8'(FAST_QTR);
  localparam logic [3:0] PKT_BITS = 4'h9;
  // register indices
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_CTRL = 3'h2;
  localparam logic [2:0] REG_CMD = 3'h3;
  localparam logic [2:0] REG_COUNT = 3'h4;
  localparam logic [2:0] REG_ERROR = 3'h5;
  // status bits
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_START = 1;
  localparam int unsigned ST_COLL = 2;
  localparam int unsigned ST_STOP = 3;
  localparam int unsigned ST_BUSY = 4;
  // control bits
  localparam int unsigned CT_FAST = 0;
  localparam int unsigned CT_CLK0 = 1;
  localparam int unsigned CT_STEP = 3;
  // command bits
  localparam int unsigned CM_GO = 0;
  localparam int unsigned CM_STOP = 1;
  // clock source selection
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_SOFT = 2'h2;
  // error codes and control register reset value
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_NACK_DATA = 8'h05;
  localparam logic [7:0] ERR_NACK_ADDR = 8'h06;
  localparam logic [7:0] ERR_NO_START = 8'h07;
  localparam logic [7:0] ERR_NO_STOP = 8'h08;
  localparam logic [7:0] RESET_CTRL = 8'h01;
  typedef enum logic [2:0] {
    IDLE = 3'b000,
    START = 3'b001,
    BITS = 3'b011,
    HOLD = 3'b010,
    STOP = 3'b110
  } state_e;
endpackage

/* File: src/tw_master.sv */
// two-wire master around an 8-bit shift register and a 4-bit bit counter
// assumes external pull-ups and slaves that may stretch the clock line
// How it works
// - start: data falls while clock high
// - stop: data rises while clock high
// - address plus direction follows each start
// - address nack abandons the transfer
// - direction bit selects byte sender
// - packet is nine clock periods
// - receiver pulls data low on ninth; master as receiver only before its last byte, no stop pending
// - high on ninth read as nack
// - master makes clock, start and stop
// - master drives clock line, slaves only stretch it low
// - stretched clock low stalls the sequence
// - several bytes per direction allowed
// - one shared unbuffered shift register
// - bit counter steps with shift clock
// - counter end sets done flag
// - shift clock: pin, timer or software
// - start, collision, stop detector flags
// - hold clock low after completion
// - read sends address, receives count bytes
// - reset leaves lines released, idle
// - standard or fast rate selectable
// - single master, no arbitration
// - missing start or stop reported
`timescale 1ns/1ns
module tw_master (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic timer_match,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  tw_pkg::state_e st_q, st_d;
  logic [1:0] scl_s_q, sda_s_q;
  logic scl_q, sda_q, scl_p_q, sda_p_q;
  logic [7:0] shift_q, stat_q, ctrl_q, count_q, err_q, rdata_q, div_q;
  logic [3:0] cnt_q;
  logic [1:0] ph_q;
  logic scl_drv_q, sda_drv_q, rx_q, first_q, nack_q, stop_pend_q, seen_q;
  wire fast = ctrl_q[tw_pkg::CT_FAST];
  wire [1:0] src = ctrl_q[tw_pkg::CT_CLK0+1:tw_pkg::CT_CLK0];
  wire [7:0] qtr = fast ? tw_pkg::FAST_QTR_C : tw_pkg::STD_QTR_C;
  wire wr_data = wr && addr == tw_pkg::REG_DATA;
  wire wr_stat = wr && addr == tw_pkg::REG_STATUS;
  wire wr_ctrl = wr && addr == tw_pkg::REG_CTRL;
  wire wr_cmd = wr && addr == tw_pkg::REG_CMD;
  wire wr_cnt = wr && addr == tw_pkg::REG_COUNT;
  wire go = wr_cmd && wdata[tw_pkg::CM_GO];
  wire stop_req = wr_cmd && wdata[tw_pkg::CM_STOP];
  wire soft_step = wr_ctrl && wdata[tw_pkg::CT_STEP];
  // released clock but line low means a slave is stretching
  wire stretched = !scl_drv_q && !scl_q;
  wire tick = (div_q == 8'h00) && !stretched;
  wire det_start = scl_q && scl_p_q && sda_p_q && !sda_q;
  wire det_stop = scl_q && scl_p_q && !sda_p_q && sda_q;
  wire coll = (st_q == tw_pkg::BITS) && !sda_drv_q && !sda_q && scl_q && !scl_p_q
              && !(rx_q || cnt_q == tw_pkg::PKT_BITS - 4'h1) ? 1'b1 : 1'b0;
  wire scl_rise = scl_q && !scl_p_q;
  wire shift_clk = (src == tw_pkg::SRC_PIN) ? scl_rise :
                   (src == tw_pkg::SRC_TIMER) ? timer_match : soft_step;
  wire bit_edge = (st_q == tw_pkg::BITS) && shift_clk && ph_q == 2'h2;
  wire last_bit = cnt_q == tw_pkg::PKT_BITS - 4'h1;
  // counter has already stepped past the ack bit when its high quarter ends
  wire pkt_end = cnt_q == tw_pkg::PKT_BITS;
  // hold keeps the bus claimed but is not busy: software may stop or restart
  wire busy = (st_q != tw_pkg::IDLE) && (st_q != tw_pkg::HOLD);
  wire data_bit = cnt_q < tw_pkg::PKT_BITS - 4'h1;
  wire bytes_left = count_q != 8'h00;
  wire [7:0] rd_mux = (addr == tw_pkg::REG_DATA) ? shift_q :
                      (addr == tw_pkg::REG_STATUS) ? {stat_q[7:5], busy,
                                                      stat_q[3:0]} :
                      (addr == tw_pkg::REG_CTRL) ? ctrl_q :
                      (addr == tw_pkg::REG_COUNT) ? count_q :
                      (addr == tw_pkg::REG_ERROR) ? err_q : 8'h00;
  // pins pass three register stages before use; first stage read only by the second
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_q <= 8'h00;
    end else if (st_q == tw_pkg::IDLE || st_q == tw_pkg::HOLD || tick) begin
      div_q <= qtr - 8'h1;
    end else if (!stretched) begin
      div_q <= div_q - 8'h1;
    end
  end
  always_comb begin
    st_d = st_q;
    case (st_q)
      tw_pkg::IDLE, tw_pkg::HOLD: begin
        if (go) begin
          st_d = tw_pkg::START;
        end else if (stop_req) begin
          st_d = tw_pkg::STOP;
        end
      end
      tw_pkg::START: begin
        if (tick && ph_q == 2'h3) begin
          st_d = tw_pkg::BITS;
        end
      end
      tw_pkg::BITS: begin
        if (tick && ph_q == 2'h3 && pkt_end) begin
          st_d = (nack_q || stop_pend_q) ? tw_pkg::STOP :
                 bytes_left ? tw_pkg::BITS : tw_pkg::HOLD;
        end
      end
      tw_pkg::STOP: begin
        if (tick && ph_q == 2'h3) begin
          st_d = tw_pkg::IDLE;
        end
      end
      default: st_d = tw_pkg::IDLE;
    endcase
  end
  // four quarters per bit: 0 clock low set data, 1 low, 2 clock high, 3 high
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q <= tw_pkg::IDLE;
      ph_q <= 2'h0;
      cnt_q <= 4'h0;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
      first_q <= 1'b0;
      rx_q <= 1'b0;
      nack_q <= 1'b0;
      stop_pend_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q != st_d) begin
        ph_q <= 2'h0;
      end else if (tick) begin
        ph_q <= ph_q + 2'h1;
      end
      if (stop_req) begin
        stop_pend_q <= 1'b1;
      end else if (st_q == tw_pkg::IDLE) begin
        stop_pend_q <= 1'b0;
      end
      if (det_start || det_stop) begin
        seen_q <= 1'b1;
      end else if (st_q != st_d) begin
        seen_q <= 1'b0;
      end
      case (st_q)
        tw_pkg::IDLE, tw_pkg::HOLD: begin
          cnt_q <= 4'h0;
          if (go) begin
            // repeated start from hold: raise data before clock
            sda_drv_q <= 1'b0;
            first_q <= 1'b1;
            nack_q <= 1'b0;
          end
          if (stop_req) begin
            sda_drv_q <= 1'b1;
          end
        end
        tw_pkg::START: begin
          if (tick && ph_q == 2'h0) begin
            scl_drv_q <= 1'b0;
          end
          if (tick && ph_q == 2'h1) begin
            sda_drv_q <= 1'b1;
          end
          if (tick && ph_q == 2'h3) begin
            scl_drv_q <= 1'b1;
            rx_q <= 1'b0;
          end
        end
        tw_pkg::BITS: begin
          if (tick && ph_q == 2'h0) begin
            // data only changes with clock low, msb first
            sda_drv_q <= data_bit ? (!rx_q && !shift_q[7]) :
                         (rx_q && bytes_left && count_q != 8'h01 && !stop_pend_q);
          end
          if (tick && ph_q == 2'h1) begin
            scl_drv_q <= 1'b0;
          end
          if (bit_edge) begin
            cnt_q <= cnt_q + 4'h1;
            if (last_bit && !rx_q && sda_q) begin
              nack_q <= 1'b1;
            end
          end
          if (tick && ph_q == 2'h3) begin
            scl_drv_q <= 1'b1;
            if (pkt_end) begin
              cnt_q <= 4'h0;
              first_q <= 1'b0;
              if (first_q) begin
                rx_q <= shift_q[0];
              end
            end
          end
        end
        tw_pkg::STOP: begin
          if (tick && ph_q == 2'h0) begin
            scl_drv_q <= 1'b1;
            sda_drv_q <= 1'b1;
          end
          if (tick && ph_q == 2'h1) begin
            scl_drv_q <= 1'b0;
          end
          // release data a quarter early so the detector sees the stop before idle
          if (tick && ph_q == 2'h2) begin
            sda_drv_q <= 1'b0;
          end
        end
        default: begin
          scl_drv_q <= 1'b0;
        end
      endcase
    end
  end
  // one register shifts both ways; a new byte overwrites the last one
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      shift_q <= 8'h00;
    end else if (bit_edge && data_bit) begin
      shift_q <= {shift_q[6:0], sda_q};
    end else if (wr_data) begin
      shift_q <= wdata;
    end
  end
  // flags: hardware set wins over software clear (write one to clear)
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stat_q <= 8'h00;
    end else begin
      stat_q[tw_pkg::ST_DONE] <= (bit_edge && last_bit) ||
        (stat_q[tw_pkg::ST_DONE] && !(wr_stat && wdata[tw_pkg::ST_DONE]));
      stat_q[tw_pkg::ST_START] <= det_start ||
        (stat_q[tw_pkg::ST_START] && !(wr_stat && wdata[tw_pkg::ST_START]));
      stat_q[tw_pkg::ST_COLL] <= coll ||
        (stat_q[tw_pkg::ST_COLL] && !(wr_stat && wdata[tw_pkg::ST_COLL]));
      stat_q[tw_pkg::ST_STOP] <= det_stop ||
        (stat_q[tw_pkg::ST_STOP] && !(wr_stat && wdata[tw_pkg::ST_STOP]));
      stat_q[7:4] <= {1'b0, cnt_q[2:0]};
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= tw_pkg::RESET_CTRL;
      count_q <= 8'h00;
      err_q <= tw_pkg::ERR_NONE;
      rdata_q <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {wdata[7:4], 1'b0, wdata[2:0]};
      end
      if (wr_cnt) begin
        count_q <= wdata;
      end else if (bit_edge && last_bit && !first_q && bytes_left) begin
        count_q <= count_q - 8'h01;
      end
      if (go) begin
        err_q <= tw_pkg::ERR_NONE;
      end else if (st_q == tw_pkg::START && tick && ph_q == 2'h3 && !seen_q) begin
        err_q <= tw_pkg::ERR_NO_START;
      end else if (st_q == tw_pkg::STOP && st_d == tw_pkg::IDLE && !seen_q && !det_stop) begin
        err_q <= tw_pkg::ERR_NO_STOP;
      end else if (bit_edge && last_bit && !rx_q && sda_q) begin
        err_q <= first_q ? tw_pkg::ERR_NACK_ADDR : tw_pkg::ERR_NACK_DATA;
      end
      rdata_q <= rd ? rd_mux : 8'h00;
    end
  end
  // hold state keeps clock driven low to claim the bus; single master assumed
  assign rdata = rdata_q;
  assign scl_out = 1'b0;
  assign scl_oe_n = !scl_drv_q;
  assign sda_out = 1'b0;
  assign sda_oe_n = !sda_drv_q;
  property p_stop_release;
    @(posedge sys_clk) disable iff (reset)
      (st_q == tw_pkg::STOP && st_d == tw_pkg::IDLE) |=> !sda_drv_q && !scl_drv_q;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("stop left lines driven");
  property p_hold_low;
    @(posedge sys_clk) disable iff (reset)
      (st_q == tw_pkg::HOLD) |-> scl_drv_q;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("hold without clock low");
  property p_stretch;
    @(posedge sys_clk) disable iff (reset)
      stretched |=> $stable(cnt_q);
  endproperty
  a_stretch: assert property (p_stretch) else $error("counter moved during stretch");
  property p_cnt_max;
    @(posedge sys_clk) disable iff (reset)
      cnt_q <= tw_pkg::PKT_BITS;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("packet longer than nine");
  property p_done;
    @(posedge sys_clk) disable iff (reset)
      (bit_edge && last_bit) |=> stat_q[tw_pkg::ST_DONE];
  endproperty
  a_done: assert property (p_done) else $error("done flag missed");
  property p_nack_stop;
    @(posedge sys_clk) disable iff (reset)
      (st_q == tw_pkg::BITS && st_d != tw_pkg::BITS && nack_q) |=> st_q == tw_pkg::STOP;
  endproperty
  a_nack_stop: assert property (p_nack_stop) else $error("nack did not abandon");
  property p_reset_idle;
    @(posedge sys_clk) $fell(reset) |-> !scl_drv_q && !sda_drv_q && st_q == tw_pkg::IDLE;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("lines not released");
  property p_start_order;
    @(posedge sys_clk) disable iff (reset)
      (st_q == tw_pkg::START && $rose(sda_drv_q)) |-> !scl_drv_q;
  endproperty
  a_start_order: assert property (p_start_order) else $error("start with clock low");
  property p_idle_free;
    @(posedge sys_clk) disable iff (reset)
      (st_q == tw_pkg::IDLE) |-> !scl_drv_q;
  endproperty
  a_idle_free: assert property (p_idle_free) else $error("idle with clock driven");
endmodule

/* File: bench/tw_slave_model.sv */
// behavioural two-wire slave for the master bench: one address, acks, sends a byte, stretches
// assumes pulled-up lines resolved by the bench and a sys_clk fast enough to see every edge
`timescale 1ns/1ns
module tw_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] tx_byte,
  input wire logic [7:0] stretch,
  output logic sda_low,
  output logic scl_low,
  output logic [7:0] rx_byte
);
  logic scl_p, sda_p, sel, rdm, adr;
  logic [3:0] cnt;
  logic [7:0] sh, st;
  assign scl_low = (st != 8'h00);
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      st <= 8'h00;
      cnt <= 4'h0;
      sel <= 1'b0;
      rdm <= 1'b0;
      adr <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      scl_p <= scl;
      sda_p <= sda;
      if (st != 8'h00)
        st <= st - 8'h01;
      if (scl && scl_p && sda_p && !sda) begin
        cnt <= 4'h0;
        adr <= 1'b1;
        rdm <= 1'b0;
      end else if (scl && scl_p && !sda_p && sda) begin
        adr <= 1'b0;
        rdm <= 1'b0;
        sel <= 1'b0;
        sda_low <= 1'b0;
      end else if (scl && !scl_p) begin
        if (cnt < 4'h8)
          sh <= {sh[6:0], sda};
        // a released line on the ninth bit ends the read
        if (cnt == 4'h8 && rdm && sda)
          rdm <= 1'b0;
        cnt <= cnt + 4'h1;
      end else if (!scl && scl_p) begin
        if (cnt == 4'h8) begin
          rx_byte <= sh;
          st <= stretch;
          if (adr) begin
            adr <= 1'b0;
            sel <= (sh[7:1] == DEV_ADDR);
            rdm <= (sh[7:1] == DEV_ADDR) && sh[0];
            sda_low <= (sh[7:1] == DEV_ADDR);
          end else begin
            sda_low <= sel && !rdm;
          end
        end else if (cnt == 4'h9) begin
          cnt <= 4'h0;
          sda_low <= rdm && !tx_byte[7];
        end else begin
          sda_low <= rdm && !tx_byte[3'h7 - cnt[2:0]];
        end
      end
    end
  end
endmodule

/* File: bench/shift_unit_two_wire_master_bench.sv */
// self-checking bench for the two-wire master with a slave model on pulled-up lines
// assumes tw_pkg, tw_master and tw_slave_model are compiled first
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module shift_unit_two_wire_master_bench;
  localparam logic [6:0] DEV = 7'h2A;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic chk = 1'b0;
  logic chk_d = 1'b0;
  logic timer_match = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [7:0] stretch = 8'h00;
  logic [7:0] rdata, rx, v, v2, st, d;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, s_sda_low, s_scl_low, scl, sda;
  logic scl_p = 1'b1;
  logic sda_p = 1'b1;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int n_st = 0;
  int n_sp = 0;
  int per = 0;
  int minp = 999;
  // lines are open drain with pull-ups
  assign scl = !((!scl_oe_n && !scl_out) || s_scl_low);
  assign sda = !((!sda_oe_n && !sda_out) || s_sda_low);
  tw_master uut (.sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_match(timer_match), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  tw_slave_model #(.DEV_ADDR(DEV)) slave (.sys_clk(sys_clk), .reset(reset), .scl(scl),
    .sda(sda), .tx_byte(tx), .stretch(stretch), .sda_low(s_sda_low), .scl_low(s_scl_low),
    .rx_byte(rx));
  always #50 sys_clk = !sys_clk;
  // timer events must be ignored while the pin is the shift clock
  always @(posedge sys_clk) timer_match <= 1'($urandom);
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      close_out();
    end
  end
  always @(posedge sys_clk) begin
    scl_p <= scl;
    sda_p <= sda;
    per <= (scl && !scl_p) ? 0 : per + 1;
    if (scl && !scl_p && per + 1 < minp)
      minp <= per + 1;
    if (scl && scl_p && sda_p && !sda)
      n_st <= n_st + 1;
    if (scl && scl_p && !sda_p && sda)
      n_sp <= n_sp + 1;
  end
  always @(posedge sys_clk) chk_d <= chk;
  always @(negedge sys_clk) begin
    if (chk_d) begin
      v = exp_q.pop_front();
      `CHK("rdata", v, rdata)
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] w);
    addr <= a;
    wdata <= w;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic c, input logic [7:0] e,
    output logic [7:0] o);
    if (c)
      exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    chk <= c;
    @(posedge sys_clk);
    rd <= 1'b0;
    chk <= 1'b0;
    @(negedge sys_clk);
    o = rdata;
    @(posedge sys_clk);
  endtask
  // polling is bounded by the cycle ceiling above
  task automatic wait_idle();
    st = 8'hFF;
    while (st[tw_pkg::ST_BUSY] !== 1'b0)
      rd_reg(tw_pkg::REG_STATUS, 1'b0, 8'h00, st);
  endtask
  task automatic xfer(input logic [7:0] ctl, input logic [7:0] ab, input logic [7:0] n);
    wr_reg(tw_pkg::REG_CTRL, ctl);
    wr_reg(tw_pkg::REG_STATUS, 8'h0F);
    wr_reg(tw_pkg::REG_DATA, ab);
    wr_reg(tw_pkg::REG_COUNT, n);
    wr_reg(tw_pkg::REG_CMD, 8'(1 << tw_pkg::CM_GO));
    wait_idle();
  endtask
  task automatic stop_bus();
    wr_reg(tw_pkg::REG_CMD, 8'(1 << tw_pkg::CM_STOP));
    wait_idle();
  endtask
  initial begin
    void'($urandom(32'h5f32cb7e));
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    `CHK("scl_oe_n", 1'b1, scl_oe_n)
    `CHK("sda_oe_n", 1'b1, sda_oe_n)
    rd_reg(tw_pkg::REG_CTRL, 1'b1, tw_pkg::RESET_CTRL, v2);
    rd_reg(tw_pkg::REG_ERROR, 1'b1, tw_pkg::ERR_NONE, v2);
    rd_reg(3'h6, 1'b1, 8'h00, v2);
    d = 8'($urandom);
    wr_reg(tw_pkg::REG_DATA, d);
    rd_reg(tw_pkg::REG_DATA, 1'b1, d, v2);
    xfer(8'h00, {DEV, 1'b0}, 8'h00);
    `CHK("address byte", {DEV, 1'b0}, rx)
    `CHK("scl hold", 1'b0, scl_oe_n)
    rd_reg(tw_pkg::REG_ERROR, 1'b1, tw_pkg::ERR_NONE, v2);
    stop_bus();
    `CHK("flags", 3'b101, st[3:1])
    `CHK("starts", 1, n_st)
    `CHK("stops", 1, n_sp)
    `CHK("scl free", 1'b1, scl_oe_n)
    `CHK("std rate", 1'b1, minp >= 4 * tw_pkg::STD_QTR)
    // unanswered address: transfer abandoned, bus freed
    xfer(8'(1 << tw_pkg::CT_FAST), {DEV ^ 7'h01, 1'b0}, 8'h00);
    rd_reg(tw_pkg::REG_ERROR, 1'b1, tw_pkg::ERR_NACK_ADDR, v2);
    `CHK("nack stop", 2, n_sp)
    `CHK("fast rate", 1'b1, minp >= 4 * tw_pkg::FAST_QTR && minp < 4 * tw_pkg::STD_QTR)
    tx = 8'($urandom);
    stretch = 8'h3C;
    xfer(8'(1 << tw_pkg::CT_FAST), {DEV, 1'b1}, 8'h01);
    rd_reg(tw_pkg::REG_DATA, 1'b1, tx, v2);
    stop_bus();
    rd_reg(tw_pkg::REG_ERROR, 1'b1, tw_pkg::ERR_NONE, v2);
    `CHK("starts", 3, n_st)
    `CHK("stops", 3, n_sp)
    `CHK("sda free", 1'b1, sda_oe_n)
    close_out();
  end
endmodule
